// [rtl/lsc_pkg.sv]
/*
 * Package for the low-speed control block of a pluggable optical module:
 * sequencer states, register offsets, field positions, reset values, timing.
 * Assumes a 100 MHz core clock and byte-wide management registers.
 */
package lsc_pkg;

    typedef enum logic [1:0] {
        ST_RESET,
        ST_SETTLE,
        ST_RUN,
        ST_STANDBY
    } seq_state_t;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_FLAGS  = 8'h54;
    localparam logic [7:0] REG_MASK   = 8'h55;
    localparam logic [7:0] REG_STATUS = 8'h56;
    localparam logic [7:0] REG_CTRL   = 8'h57;

    localparam int FLAG_RESET_DONE = 0;
    localparam int FLAG_NOT_READY  = 1;
    localparam int NUM_FLAGS       = 2;

    localparam int CTRL_SOFT_TRANSMIT_DISABLE_IN = 0;

    localparam logic [1:0] MASK_RESET_VAL  = 2'h3;
    localparam logic [1:0] FLAGS_RESET_VAL = 2'h0;

    // ------------------------------------------------------------------
    // Pin inputs: tx disable, power down, tx lock loss, laser fault,
    // rx lock loss, rx power low; all idle high like a pulled-up pin
    // ------------------------------------------------------------------
    localparam int         PIN_W         = 6;
    localparam logic [5:0] PIN_RESET_VAL = 6'h3F;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_INIT_US     = 1000;
    localparam int T_INIT_CYCLES = (T_INIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// [rtl/pin_sync.sv]
/*
 * Two-flop synchroniser for a group of asynchronous level inputs.
 * Assumes every bit is a slow level; no bit relation is kept across bits.
 */
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int              WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_r  <= RESET_VAL;
            syncOut <= RESET_VAL;
        end else begin
            meta_r  <= asyncIn;
            syncOut <= meta_r;
        end
    end

endmodule
`default_nettype wire

// [rtl/init_timer.sv]
/*
 * Reset duration timer. Runs once out of reset, restarts on start,
 * pulses done for one cycle when the count expires.
 * Assumes start is a one-cycle pulse from the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
module init_timer #(
    parameter int CYCLES = 16
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    output logic      done
);

    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] count_r;
    logic          active_r;

    // Power-on counts as a reset, so the timer comes up running
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count_r  <= '0;
            active_r <= 1'b1;
            done     <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                count_r  <= '0;
                active_r <= 1'b1;
            end else if (active_r) begin
                if (count_r == LAST) begin
                    active_r <= 1'b0;
                    done     <= 1'b1;
                end else begin
                    count_r <= count_r + 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [rtl/module_lowspeed_control.sv]
/*
 * Low-speed control and status of a pluggable optical module: power-down
 * and reset sequencing, fault gating, interrupt flags and a byte register
 * port for the management side.
 * Assumes the pins are asynchronous levels already pulled up outside, and
 * that the register port is driven from logic on clk.
 */
// Operation
// RQ1: Transmit disable high keeps the laser switched off.
// RQ2: Absent output reads low whenever this module is plugged in.
// RQ3: Loss-of-signal output high when received power is too low.
// RQ4: Power-down high holds standby, low power asserted.
// RQ5: Register port and laser safety keep working in standby.
// RQ6: Falling edge of power-down starts a complete reset; an edge during ST_SETTLE goes to ST_RUN without a reset.
// RQ7: Host ignores not-ready, loss-of-signal, flags except reset-done during reset.
// RQ8: Valid not-ready and loss-of-signal shown before reset-done flag sets.
// RQ9: Interrupt never asserts without a set, enabled flag.
// RQ10: Power-up with power-down asserted comes up in standby.
// RQ11: In standby only the reset-done flag may be set.
// RQ12: Host clears reset-done before releasing power-down.
// RQ13: Leaving standby runs another reset and second reset-done flag.
// RQ14: Undriven control inputs read high: laser off, standby.
// RQ15: Not-ready is the OR of tx lock loss, laser fault, rx lock loss.
// RQ16: Interrupt output is active low.
// RQ17: Interrupt holds while any enabled flag set, releases when cleared.
`timescale 1ns/10ps
`default_nettype none
module module_lowspeed_control
    import lsc_pkg::*;
#(
    parameter int INIT_CYCLES = T_INIT_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       arst_n,
    input  wire logic       transmit_disable_in,
    input  wire logic       powerDownIn,
    input  wire logic       txLossOfLockIn,
    input  wire logic       laserFaultIn,
    input  wire logic       rxLossOfLockIn,
    input  wire logic       rxPowerLowIn,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdData,
    output logic            laserEnableOut,
    output logic            lowPowerOut,
    output logic            moduleAbsentOut,
    output logic            rxLosOut,
    output logic            module_not_ready_out,
    output logic            interruptOut_n
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        seq_state_t           state;
        logic                 pdPrev;
        logic                 timerStart;
        logic                 nrPrev;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] mask;
        logic                 softTxDis;
        logic [7:0]           rdData;
        logic                 laserEn;
        logic                 lowPower;
        logic                 absent;
        logic                 los;
        logic                 notReady;
        logic                 intN;
    } lsc_state_t;

    localparam lsc_state_t STATE_RESET = '{
        state:      ST_RESET,
        pdPrev:     1'b1,
        timerStart: 1'b0,
        nrPrev:     1'b1,
        flags:      FLAGS_RESET_VAL,
        mask:       MASK_RESET_VAL,
        softTxDis:  1'b0,
        rdData:     8'h00,
        laserEn:    1'b0,
        lowPower:   1'b1,
        absent:     1'b0,
        los:        1'b1,
        notReady:   1'b1,
        intN:       1'b1
    };

    lsc_state_t s_r;
    lsc_state_t s_nxt;

    // ------------------------------------------------------------------
    // Pin synchronisers and reset timer
    // ------------------------------------------------------------------
    logic [PIN_W-1:0] pinS;
    logic             txDisS;
    logic             pdS;
    logic             txLolS;
    logic             laserFaultS;
    logic             rxLolS;
    logic             rxPowerLowS;
    logic             timerDone;
    logic             faultNow;
    logic             pdFell;
    logic             wrFlags;
    logic             setResetDone;
    logic             setNotReady;

    // Reset values high so floating controls mean laser off and standby
    pin_sync #(
        .WIDTH     (PIN_W),
        .RESET_VAL (PIN_RESET_VAL)
    ) u_pin_sync (
        .clk     (clk),
        .arst_n  (arst_n),
        .asyncIn ({transmit_disable_in, powerDownIn, txLossOfLockIn,
                   laserFaultIn, rxLossOfLockIn, rxPowerLowIn}),
        .syncOut (pinS)
    ); // RQ14

    assign {txDisS, pdS, txLolS, laserFaultS, rxLolS, rxPowerLowS} = pinS;

    init_timer #(
        .CYCLES (INIT_CYCLES)
    ) u_init_timer (
        .clk    (clk),
        .arst_n (arst_n),
        .start  (s_r.timerStart),
        .done   (timerDone)
    );

    assign faultNow = txLolS | laserFaultS | rxLolS; // RQ15
    assign pdFell   = s_r.pdPrev & ~pdS;
    assign wrFlags  = regWr && (regAddr == REG_FLAGS);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_nxt            = s_r;
        s_nxt.pdPrev     = pdS;
        s_nxt.timerStart = 1'b0;
        setResetDone     = 1'b0;
        setNotReady      = 1'b0;

        case (s_r.state)
            ST_RESET: begin
                // A stale done from an earlier run is dropped while restarting
                if (pdFell) begin
                    s_nxt.timerStart = 1'b1; // RQ6
                end else if (timerDone && !s_r.timerStart) begin
                    s_nxt.state = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // Outputs carry live values here, one cycle ahead of the flag
                setResetDone = 1'b1; // RQ8
                s_nxt.state  = pdS ? ST_STANDBY : ST_RUN; // RQ10
            end
            ST_RUN: begin
                if (pdS) begin
                    s_nxt.state = ST_STANDBY; // RQ4
                end else begin
                    setNotReady = faultNow && !s_r.nrPrev;
                end
            end
            ST_STANDBY: begin
                if (pdFell) begin
                    s_nxt.state      = ST_RESET; // RQ13
                    s_nxt.timerStart = 1'b1;
                end
            end
            default: begin
                s_nxt.state      = ST_RESET;
                s_nxt.timerStart = 1'b1;
            end
        endcase

        if (s_r.state == ST_RUN && pdFell) begin
            s_nxt.state      = ST_RESET; // RQ6
            s_nxt.timerStart = 1'b1;
        end

        s_nxt.nrPrev = faultNow;

        // Write-one-to-clear; a new event in the same cycle wins
        s_nxt.flags = s_r.flags & ~(wrFlags ? regWrData[NUM_FLAGS-1:0] : '0);
        s_nxt.flags[FLAG_RESET_DONE] = s_nxt.flags[FLAG_RESET_DONE] | setResetDone;
        s_nxt.flags[FLAG_NOT_READY]  = s_nxt.flags[FLAG_NOT_READY] | setNotReady; // RQ11

        if (regWr && regAddr == REG_MASK) begin
            s_nxt.mask = regWrData[NUM_FLAGS-1:0];
        end
        if (regWr && regAddr == REG_CTRL) begin
            s_nxt.softTxDis = regWrData[CTRL_SOFT_TRANSMIT_DISABLE_IN];
        end

        // Register port is served in every state, standby included
        s_nxt.rdData = 8'h00; // RQ5
        if (regRd) begin
            case (regAddr)
                REG_FLAGS:  s_nxt.rdData = {6'h00, s_r.flags};
                REG_MASK:   s_nxt.rdData = {6'h00, s_r.mask};
                REG_STATUS: s_nxt.rdData = {1'b0, s_r.state == ST_STANDBY,
                                            faultNow, rxPowerLowS, txLolS,
                                            laserFaultS, rxLolS, pdS};
                REG_CTRL:   s_nxt.rdData = {7'h00, s_r.softTxDis};
                default:    s_nxt.rdData = 8'h00;
            endcase
        end

        // Laser off on pin, soft disable, laser fault, reset or standby
        s_nxt.laserEn  = !txDisS && !s_r.softTxDis && !laserFaultS
                         && (s_nxt.state == ST_RUN); // RQ1
        s_nxt.lowPower = pdS || (s_nxt.state == ST_STANDBY); // RQ4
        s_nxt.absent   = 1'b0; // RQ2

        // Parked high while untrusted; live from SETTLE on, ahead of the flag
        if (s_nxt.state == ST_RUN || s_nxt.state == ST_SETTLE) begin
            s_nxt.los      = rxPowerLowS; // RQ3
            s_nxt.notReady = faultNow;    // RQ15
        end else begin
            s_nxt.los      = 1'b1; // RQ7
            s_nxt.notReady = 1'b1;
        end

        s_nxt.intN = ~|(s_nxt.flags & s_nxt.mask); // RQ9 RQ16 RQ17
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_r <= STATE_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdData            = s_r.rdData;
    assign laserEnableOut       = s_r.laserEn;
    assign lowPowerOut          = s_r.lowPower;
    assign moduleAbsentOut      = s_r.absent;
    assign rxLosOut             = s_r.los;
    assign module_not_ready_out = s_r.notReady;
    assign interruptOut_n       = s_r.intN;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    tx_off_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
        txDisS |=> !laserEnableOut)
        else $error("laser on while transmit disable high");

    absent_low_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ2
        !moduleAbsentOut)
        else $error("absent output high with module present");

    los_follow_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ3
        (s_r.state == ST_RUN) ##1 (s_r.state == ST_RUN)
        |-> rxLosOut == $past(rxPowerLowS))
        else $error("loss of signal does not follow rx power");

    standby_power_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
        (s_r.state == ST_STANDBY) |-> lowPowerOut && !laserEnableOut)
        else $error("standby without low power");

    reset_on_fall_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ6
        (s_r.state inside {ST_RUN, ST_STANDBY}) && s_r.pdPrev && !pdS
        |=> s_r.state == ST_RESET && s_r.timerStart)
        else $error("falling power down did not start reset");

    ready_first_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ8
        $rose(s_r.flags[FLAG_RESET_DONE])
        |-> $past(s_r.state) == ST_SETTLE
            && $past(module_not_ready_out) == $past(faultNow, 2))
        else $error("reset done flagged before outputs valid");

    no_spurious_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ9
        !interruptOut_n |-> |(s_r.flags & s_r.mask))
        else $error("interrupt without enabled flag");

    standby_flags_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ11
        (s_r.state == ST_STANDBY) ##1 (s_r.state == ST_STANDBY)
        |-> !$rose(s_r.flags[FLAG_NOT_READY]))
        else $error("fault flag set during standby");

    int_hold_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ17
        |(s_r.flags & s_r.mask) |-> !interruptOut_n)
        else $error("interrupt released with flag pending");

    settle_one_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ13
        (s_r.state == ST_SETTLE)
        |=> s_r.state inside {ST_RUN, ST_STANDBY} && s_r.flags[FLAG_RESET_DONE])
        else $error("reset completion not posted");

    rd_idle_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ5
        !regRd |=> regRdData == 8'h00)
        else $error("read data not zero outside read answer");

    nr_flag_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ11
        $rose(s_r.flags[FLAG_NOT_READY]) |-> $past(s_r.state) == ST_RUN)
        else $error("fault flag set outside normal operation");

    park_outputs_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ7
        (s_r.state inside {ST_RESET, ST_STANDBY}) |-> rxLosOut && module_not_ready_out)
        else $error("status outputs not parked during reset or standby");

    nr_or_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ15
        (s_r.state == ST_RUN) |-> module_not_ready_out == $past(faultNow))
        else $error("not ready does not follow fault sources");

    laser_run_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
        laserEnableOut |-> (s_r.state == ST_RUN))
        else $error("laser on outside normal operation");

    soft_dis_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ1
        s_r.softTxDis |=> !laserEnableOut)
        else $error("laser on while soft disable set");

    pd_standby_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
        (s_r.state == ST_RUN) && pdS |=> (s_r.state == ST_STANDBY))
        else $error("power down high did not enter standby");

    int_done_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ16
        (s_r.state == ST_SETTLE) |=> !interruptOut_n || !s_r.mask[FLAG_RESET_DONE])
        else $error("reset completion not driven low on interrupt");

    run_power_a: assert property (@(posedge clk) disable iff (!arst_n) // RQ4
        (s_r.state == ST_RUN) |-> !lowPowerOut)
        else $error("low power flagged in normal operation");

endmodule
`default_nettype wire

// [tb/host_pin_model.sv]
/*
 * Host board side of the low-speed pins: transmit disable and power-down.
 * Assumes the bench drives its requests on clk; a released pin floats high.
 */
`timescale 1ns/10ps
`default_nettype none
module host_pin_model (
    input  wire logic clk,
    input  wire logic driveEn,
    input  wire logic pdLevel,
    input  wire logic txLevel,
    output logic      powerDownPin,
    output logic      txDisablePin
);
    // Undriven pins read high through the module pull-ups
    always @(posedge clk) begin
        powerDownPin <= driveEn ? pdLevel : 1'b1;
        txDisablePin <= driveEn ? txLevel : 1'b1;
    end
endmodule
`default_nettype wire

// [tb/tb_top.sv]
/*
 * Self-checking bench for the low-speed control block with a host pin model.
 * Assumes the package register map and a shortened reset timer.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import lsc_pkg::*;
;
    localparam int INIT = 20;
    logic       clk, arst_n, driveEn, pdLevel, txLevel, pdPin, txPin;
    logic       txLol, lasF, rxLol, rxPl, regWr, regRd;
    logic [7:0] regAddr, regWrData, regRdData;
    logic       laserEn, lowPow, absent, rxLos, notReady, interruptN;
    int         errorCnt, checks, mFlags, mMask, mSoft, k;
    logic       prevOr;
    logic [7:0] expQ[$];

    host_pin_model u_host (.clk(clk), .driveEn(driveEn), .pdLevel(pdLevel),
        .txLevel(txLevel), .powerDownPin(pdPin), .txDisablePin(txPin));

    module_lowspeed_control #(.INIT_CYCLES(INIT)) u_dut (.clk(clk), .arst_n(arst_n),
        .transmit_disable_in(txPin), .powerDownIn(pdPin), .txLossOfLockIn(txLol),
        .laserFaultIn(lasF), .rxLossOfLockIn(rxLol), .rxPowerLowIn(rxPl),
        .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
        .regRdData(regRdData), .laserEnableOut(laserEn), .lowPowerOut(lowPow),
        .moduleAbsentOut(absent), .rxLosOut(rxLos), .module_not_ready_out(notReady),
        .interruptOut_n(interruptN));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] e);
        checks++;
        if (seen !== e) begin
            errorCnt++;
            $display("[ERR] %s expected %h seen %h", n, e, seen);
        end
    endtask

    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr     <= 1'b1;
        regAddr   <= a;
        regWrData <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string n);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        expQ.push_back(e);
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chk(n, regRdData, expQ.pop_front());
    endtask

    task automatic waitInt(input logic lvl, input string n);
        k = 0;
        while (interruptN !== lvl && k < 200) begin
            idle(1);
            k++;
        end
        chk(n, {7'h00, interruptN}, {7'h00, lvl});
    endtask

    // Outputs in normal operation against the model
    task automatic cmpRun();
        chk("notReady", {7'h00, notReady}, {7'h00, txLol | lasF | rxLol});
        chk("rxLos", {7'h00, rxLos}, {7'h00, rxPl});
        chk("laser", {7'h00, laserEn}, {7'h00, !txPin && mSoft == 0 && !lasF});
        chk("intLine", {7'h00, interruptN}, {7'h00, (mFlags & mMask) == 0});
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, errorCnt);
        if (errorCnt == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Clock and watchdog
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        repeat (3000) @(posedge clk);
        errorCnt++;
        conclude();
    end

    // ------------------------------------------------------------------
    // Sequence
    // ------------------------------------------------------------------
    initial begin
        arst_n = 1'b0;  driveEn = 1'b0;  pdLevel = 1'b1;  txLevel = 1'b1;
        {txLol, lasF, rxLol, rxPl} = 4'h0;
        regAddr = 8'h00;  regWrData = 8'h00;  regWr = 1'b0;  regRd = 1'b0;
        errorCnt = 0;  checks = 0;  mFlags = 0;  mMask = 3;  mSoft = 0;
        void'($urandom(54));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        // Pins left released: power-up lands in standby
        rd(REG_MASK, 8'h03, "maskReset");
        rd(REG_FLAGS, 8'h00, "flagsReset");
        // Interrupt, low power, absent and laser are checked here; parked outputs are ignored
        waitInt(1'b0, "intStandby");
        mFlags = 1;
        chk("lowPower", {7'h00, lowPow}, 8'h01);
        chk("absent", {7'h00, absent}, 8'h00);
        chk("laserOff", {7'h00, laserEn}, 8'h00);
        @(posedge clk);
        lasF <= 1'b1;
        idle(6);
        rd(REG_FLAGS, 8'h01, "flagsStandby");
        @(posedge clk);
        lasF <= 1'b0;
        wr(REG_FLAGS, 8'h01);
        mFlags = 0;
        idle(1);
        chk("intCleared", {7'h00, interruptN}, 8'h01);
        rd(8'h00, 8'h00, "unmapped");
        // Release from standby: second reset and second completion
        @(posedge clk);
        rxPl    <= 1'($urandom);
        driveEn <= 1'b1;
        pdLevel <= 1'b0;
        txLevel <= 1'b0;
        waitInt(1'b0, "intRun");
        mFlags = 1;
        chk("losAtDone", {7'h00, rxLos}, {7'h00, rxPl});
        chk("nrAtDone", {7'h00, notReady}, 8'h00);
        chk("lowPowerRun", {7'h00, lowPow}, 8'h00);
        wr(REG_FLAGS, 8'h01);
        mFlags = 0;
        idle(6);
        cmpRun();
        prevOr = 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            {txLevel, txLol, lasF, rxLol, rxPl} <= 5'($urandom);
            idle(7);
            if ((txLol | lasF | rxLol) && !prevOr) mFlags |= 2;
            prevOr = txLol | lasF | rxLol;
            cmpRun();
        end
        rd(REG_FLAGS, 8'(mFlags), "flagsRun");
        @(posedge clk);
        {txLevel, txLol, lasF, rxLol, rxPl} <= 5'h00;
        idle(6);
        wr(REG_FLAGS, 8'h03);
        mFlags = 0;
        idle(1);
        cmpRun();
        // Masked source must not reach the line
        wr(REG_MASK, 8'h00);
        mMask = 0;
        @(posedge clk);
        lasF <= 1'b1;
        idle(7);
        mFlags = 2;
        cmpRun();
        rd(REG_FLAGS, 8'h02, "flagsMasked");
        rd(REG_MASK, 8'h00, "maskBack");
        @(posedge clk);
        lasF <= 1'b0;
        wr(REG_FLAGS, 8'h02);
        wr(REG_MASK, 8'h03);
        mFlags = 0;
        mMask = 3;
        wr(REG_CTRL, 8'h01);
        mSoft = 1;
        idle(4);
        cmpRun();
        rd(REG_CTRL, 8'h01, "ctrl");
        wr(REG_CTRL, 8'h00);
        mSoft = 0;
        idle(4);
        cmpRun();
        // Back to standby, then a falling edge restarts the reset
        @(posedge clk);
        pdLevel <= 1'b1;
        idle(6);
        chk("standbyAgain", {7'h00, lowPow}, 8'h01);
        chk("laserStandby", {7'h00, laserEn}, 8'h00);
        rd(REG_MASK, 8'h03, "maskStandby");
        rd(REG_STATUS, 8'h41, "statusStandby");
        @(posedge clk);
        pdLevel <= 1'b0;
        waitInt(1'b0, "intAfterEdge");
        conclude();
    end
endmodule
`default_nettype wire
